//--- logic/cos_conn_logic.sv
// connection-object state logic for one I/O and one explicit connection
//
// Notes on behaviour
// - send while configuring, waiting or timed out gives internal error, no transmission.
// - apply needing an identifier with none free answers resource unavailable.
// - apply conflict answers invalid attribute value, additional code the attribute id.
// - fitting received message restarts the watchdog and is delivered to the application.
// - received message longer than consumed size is dropped at once.
// - length is the only content check; the application validates the rest.
// - fragments do not restart the watchdog until the whole message arrived.
// - open request or response creates an explicit instance when resources permit.
// - other explicit attributes come from the open message; then established.
// - an open built from a request sends the open response.
// - close frees an explicit connection; a missing one answers object does not exist.
// - delete frees an explicit connection; a missing one answers object does not exist.
// - set on established explicit connection is checked, done if allowed, answered.
`timescale 1ns/1ps
module cos_conn_logic
  import cos_pkg::*;
#(
  parameter int TICK_CYCLES = cos_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_n_in,
  // register port
  input  wire logic [cos_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [cos_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [cos_pkg::DATA_W-1:0] rdata_out,
  output logic                            irq_out,
  // i/o transmit path
  input  wire logic                       io_send_in,
  input  wire logic [cos_pkg::LEN_W-1:0]  io_send_len_in,
  output logic                            io_tx_valid_out,
  output logic      [cos_pkg::LEN_W-1:0]  io_tx_bytes_out,
  output logic                            io_tx_frag_out,
  output logic                            io_tx_last_out,
  output logic                            io_int_err_out,
  // i/o receive path
  input  wire logic                       io_rx_valid_in,
  input  wire logic [cos_pkg::LEN_W-1:0]  io_rx_len_in,
  input  wire logic                       io_rx_more_in,
  output logic                            io_rx_deliver_out,
  output logic      [cos_pkg::LEN_W-1:0]  io_rx_total_out,
  // apply request
  input  wire logic                       apply_in,
  input  wire logic                       apply_need_id_in,
  input  wire logic                       apply_id_free_in,
  input  wire logic                       apply_ids_ready_in,
  input  wire logic                       apply_conflict_in,
  input  wire logic [7:0]                 apply_attr_id_in,
  // explicit connection requests from the unconnected_message_manager
  input  wire logic                       ex_open_in,
  input  wire logic                       ex_open_is_req_in,
  input  wire logic                       ex_res_ok_in,
  input  wire logic [cos_pkg::LEN_W-1:0]  ex_open_size_in,
  input  wire logic                       ex_close_in,
  input  wire logic                       ex_delete_in,
  input  wire logic                       ex_set_in,
  input  wire logic                       ex_set_allowed_in,
  input  wire logic [cos_pkg::LEN_W-1:0]  ex_set_value_in,
  output logic                            ex_open_resp_out,
  // responses
  output logic                            resp_valid_out,
  output logic      [7:0]                 resp_code_out,
  output logic      [7:0]                 resp_add_out
);
  import cos_pkg::*;

  cos_io_state_type  io_st;
  cos_ex_state_type  ex_st;
  logic [1:0]        ctrl_act;
  logic [LEN_W-1:0]  cons_size;
  logic [LEN_W-1:0]  prod_size;
  logic [EPR_W-1:0]  pkt_rate;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_mask;
  logic [7:0]        ex_type;
  logic [LEN_W-1:0]  ex_size;
  logic              rx_busy;
  logic [LEN_W:0]    rx_acc;
  logic [LEN_W-1:0]  tx_rem;
  logic              tx_fragd;
  logic [EV_W-1:0]   ev;
  logic              next_resp_valid;
  logic [7:0]        next_resp_code;
  logic [7:0]        next_resp_add;
  logic [DATA_W-1:0] next_rdata;
  logic              send_bad;
  logic              rx_fit;
  logic              rx_done;
  logic [LEN_W:0]    rx_total;
  logic              ap_est;
  logic              set_ok;
  logic              expired;
  logic [LEN_W-1:0]  tx_len;
  logic [LEN_W-1:0]  tx_chunk;
  logic              wr_create;

  cos_tmr_if #(.W(EPR_W)) tmr_bus ();

  cos_wdt #(.TICK_CYCLES(TICK_CYCLES), .W(EPR_W)) u_wdt (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .tmr        (tmr_bus.tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event decode

  // only length is checked here, contents are the application's business
  assign rx_total = (rx_busy ? rx_acc : '0) + {1'b0, io_rx_len_in};
  assign rx_fit   = rx_total <= {1'b0, cons_size};
  assign rx_done  = io_rx_valid_in && io_st == IO_EST && rx_fit && !io_rx_more_in;
  assign send_bad = io_send_in && (io_st == IO_CFG || io_st == IO_WAIT_ID ||
                                   io_st == IO_TIMED_OUT || tx_rem != '0);
  assign expired  = tmr_bus.expire && io_st == IO_EST;
  assign ap_est   = apply_in && apply_ids_ready_in && !(apply_need_id_in && !apply_id_free_in)
                    && !apply_conflict_in && (io_st == IO_CFG || io_st == IO_WAIT_ID);
  assign set_ok   = ex_set_in && ex_st == EX_EST && ex_set_allowed_in
                    && !apply_in && !ex_close_in && !ex_delete_in;
  assign wr_create = wr_in && addr_in == A_CTRL && wdata_in[CTRL_CREATE];
  assign tx_len   = (io_send_len_in > prod_size) ? prod_size : io_send_len_in;
  assign tx_chunk = (tx_rem > FRAG_BYTES) ? FRAG_BYTES : tx_rem;

  // watchdog restarts on completed reception, on establishment and on auto reset
  assign tmr_bus.restart = rx_done || ap_est
                           || (expired && ctrl_act == ACT_AUTO_RESET);
  assign tmr_bus.stop    = io_st != IO_EST && !ap_est;
  assign tmr_bus.period  = pkt_rate;

  assign ev[EV_INT_ERR]  = send_bad;
  assign ev[EV_EXPIRE]   = expired;
  assign ev[EV_DROP]     = io_rx_valid_in && io_st == IO_EST && !rx_fit;
  assign ev[EV_ERR_RESP] = next_resp_valid && next_resp_code != GEC_OK;

  ////////////////////////////////////////////////////////////////////////////
  // response selection: one answer per cycle, apply first

  always_comb begin
    next_resp_valid = 1'b1;
    next_resp_code  = GEC_OK;
    next_resp_add   = 8'h00;
    if (apply_in) begin
      if (io_st == IO_NONE) begin
        next_resp_code = GEC_NO_OBJECT;
      end else if (io_st == IO_EST || io_st == IO_TIMED_OUT) begin
        next_resp_code = GEC_BAD_STATE;
      end else if (apply_need_id_in && !apply_id_free_in) begin
        next_resp_code = GEC_RES_UNAVAIL;
      end else if (apply_conflict_in) begin
        next_resp_code = GEC_INV_ATTR;
        next_resp_add  = apply_attr_id_in;
      end
    end else if (ex_close_in || ex_delete_in) begin
      if (ex_st == EX_NONE) begin
        next_resp_code = GEC_NO_OBJECT;
      end
    end else if (ex_set_in) begin
      if (ex_st == EX_NONE) begin
        next_resp_code = GEC_NO_OBJECT;
      end else if (!ex_set_allowed_in) begin
        next_resp_code = GEC_BAD_STATE;
      end
    end else begin
      next_resp_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_valid_out <= 1'b0;
      resp_code_out  <= 8'h00;
      resp_add_out   <= 8'h00;
    end else begin
      resp_valid_out <= next_resp_valid;
      resp_code_out  <= next_resp_code;
      resp_add_out   <= next_resp_add;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i/o connection state

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_st <= IO_NONE;
    end else begin
      unique case (io_st)
        IO_NONE: begin
          if (wr_create) begin
            io_st <= IO_CFG;
          end
        end
        IO_CFG: begin
          if (ap_est) begin
            io_st <= IO_EST;
          end else if (apply_in && !(apply_need_id_in && !apply_id_free_in)
                       && !apply_conflict_in) begin
            io_st <= IO_WAIT_ID;
          end
        end
        IO_WAIT_ID: begin
          if (ap_est) begin
            io_st <= IO_EST;
          end
        end
        IO_EST: begin
          if (expired && ctrl_act == ACT_TIMED_OUT) begin
            io_st <= IO_TIMED_OUT;
          end else if (expired && ctrl_act == ACT_AUTO_DELETE) begin
            io_st <= IO_NONE;
          end
        end
        IO_TIMED_OUT: begin
          io_st <= IO_TIMED_OUT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: one fragment per cycle, a busy sender refuses new messages

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_rem          <= '0;
      tx_fragd        <= 1'b0;
      io_tx_valid_out <= 1'b0;
      io_tx_bytes_out <= '0;
      io_tx_frag_out  <= 1'b0;
      io_tx_last_out  <= 1'b0;
      io_int_err_out  <= 1'b0;
    end else begin
      io_int_err_out  <= send_bad;
      io_tx_valid_out <= tx_rem != '0;
      io_tx_bytes_out <= tx_chunk;
      io_tx_frag_out  <= tx_fragd;
      io_tx_last_out  <= tx_rem != '0 && tx_rem <= FRAG_BYTES;
      if (tx_rem != '0) begin
        tx_rem <= tx_rem - tx_chunk;
      end else if (io_send_in && io_st == IO_EST) begin
        tx_rem   <= tx_len;
        tx_fragd <= tx_len > FRAG_BYTES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: length check, fragment accumulation, delivery

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_busy           <= 1'b0;
      rx_acc            <= '0;
      io_rx_deliver_out <= 1'b0;
      io_rx_total_out   <= '0;
    end else begin
      io_rx_deliver_out <= rx_done;
      if (rx_done) begin
        io_rx_total_out <= rx_total[LEN_W-1:0];
      end
      if (io_st != IO_EST) begin
        rx_busy <= 1'b0;
      end else if (io_rx_valid_in) begin
        if (!rx_fit) begin
          rx_busy <= 1'b0;
        end else begin
          rx_busy <= io_rx_more_in;
          rx_acc  <= rx_total;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // explicit connection state

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ex_st            <= EX_NONE;
      ex_type          <= INST_IO;
      ex_size          <= '0;
      ex_open_resp_out <= 1'b0;
    end else begin
      ex_open_resp_out <= 1'b0;
      unique case (ex_st)
        EX_NONE: begin
          if (ex_open_in && ex_res_ok_in) begin
            ex_st            <= EX_EST;
            ex_type          <= INST_EXPLICIT;
            ex_size          <= ex_open_size_in;
            ex_open_resp_out <= ex_open_is_req_in;
          end
        end
        EX_EST: begin
          if (!apply_in && (ex_close_in || ex_delete_in)) begin
            ex_st <= EX_NONE;
          end else if (set_ok) begin
            ex_size <= ex_set_value_in;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and interrupt

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_act  <= ACT_TIMED_OUT;
      cons_size <= RST_CONS_SIZE;
      prod_size <= RST_PROD_SIZE;
      pkt_rate  <= RST_PKT_RATE;
      irq_mask  <= '0;
    end else if (wr_in) begin
      unique case (addr_in)
        A_CTRL:      ctrl_act  <= wdata_in[CTRL_ACT_LO +: 2];
        A_CONS_SIZE: cons_size <= wdata_in[LEN_W-1:0];
        A_PROD_SIZE: prod_size <= wdata_in[LEN_W-1:0];
        A_PKT_RATE:  pkt_rate  <= wdata_in[EPR_W-1:0];
        A_IRQ_MASK:  irq_mask  <= wdata_in[EV_W-1:0];
        default:     ;
      endcase
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat <= '0;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_in && addr_in == A_IRQ_STAT) ?
                  wdata_in[EV_W-1:0] : '0)) | ev;
      irq_out  <= |(irq_stat & irq_mask);
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    next_rdata = '0;
    unique case (addr_in)
      A_CTRL:      next_rdata[CTRL_ACT_LO +: 2] = ctrl_act;
      A_CONS_SIZE: next_rdata[LEN_W-1:0] = cons_size;
      A_PROD_SIZE: next_rdata[LEN_W-1:0] = prod_size;
      A_PKT_RATE:  next_rdata[EPR_W-1:0] = pkt_rate;
      A_STATE: begin
        next_rdata[2:0]              = io_st;
        next_rdata[ST_EX_BIT]        = ex_st;
        next_rdata[ST_BUSY_BIT]      = rx_busy;
        next_rdata[ST_TYPE_LO +: 8]  = ex_type;
        next_rdata[ST_SIZE_LO +: LEN_W] = ex_size;
      end
      A_IRQ_STAT:  next_rdata[EV_W-1:0] = irq_stat;
      A_IRQ_MASK:  next_rdata[EV_W-1:0] = irq_mask;
      default:     next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rd_in ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // a sender already busy keeps draining its message, but no new one is loaded
  property p_no_send;
    send_bad |=> io_int_err_out
      && ($past(tx_rem) != '0 || (!io_tx_valid_out && tx_rem == '0));
  endproperty
  a_no_send: assert property (p_no_send) else $error("bad send transmitted");

  property p_send;
    io_send_in && io_st == IO_EST && tx_rem == '0 && tx_len != '0 |=> ##1 io_tx_valid_out;
  endproperty
  a_send: assert property (p_send) else $error("send not transmitted");

  property p_expire;
    expired && ctrl_act == ACT_TIMED_OUT |=> io_st == IO_TIMED_OUT;
  endproperty
  a_expire: assert property (p_expire) else $error("no timed out state");

  property p_res;
    apply_in && io_st == IO_CFG && apply_need_id_in && !apply_id_free_in
      |=> resp_valid_out && resp_code_out == GEC_RES_UNAVAIL && io_st == IO_CFG;
  endproperty
  a_res: assert property (p_res) else $error("missing resource error");

  property p_conflict;
    apply_in && io_st == IO_CFG && !(apply_need_id_in && !apply_id_free_in)
      && apply_conflict_in |=> resp_code_out == GEC_INV_ATTR
      && resp_add_out == $past(apply_attr_id_in);
  endproperty
  a_conflict: assert property (p_conflict) else $error("bad conflict answer");

  property p_drop;
    io_rx_valid_in && io_st == IO_EST && !rx_fit |=> !io_rx_deliver_out && irq_stat[EV_DROP];
  endproperty
  a_drop: assert property (p_drop) else $error("long message not dropped");

  property p_frag;
    // an auto-reset expiry in the same cycle restarts the timer on its own account
    io_rx_valid_in && io_st == IO_EST && io_rx_more_in && !expired |-> !tmr_bus.restart;
  endproperty
  a_frag: assert property (p_frag) else $error("fragment restarted timer");

  property p_open;
    ex_open_in && ex_st == EX_NONE && ex_res_ok_in |=> ex_st == EX_EST
      && ex_type == INST_EXPLICIT && ex_open_resp_out == $past(ex_open_is_req_in);
  endproperty
  a_open: assert property (p_open) else $error("open not handled");

  property p_close;
    !apply_in && (ex_close_in || ex_delete_in) && ex_st == EX_NONE
      |=> resp_valid_out && resp_code_out == GEC_NO_OBJECT;
  endproperty
  a_close: assert property (p_close) else $error("missing object error");

  c_frag_rx: cover property (io_rx_valid_in && io_rx_more_in && rx_fit ##[1:8] rx_done);
  c_frag_tx: cover property (io_tx_valid_out && io_tx_frag_out && io_tx_last_out);
  c_expire:  cover property (expired);
  c_open:    cover property (ex_open_in && ex_st == EX_NONE ##[1:20] ex_close_in);
endmodule

//--- logic/cos_pkg.sv
// constants and types shared by the connection-object state logic
package cos_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEN_W  = 8;
  localparam int EPR_W  = 16;
  localparam int EV_W   = 4;
  // register offsets
  localparam logic [ADDR_W-1:0] A_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] A_CONS_SIZE = 8'h04;
  localparam logic [ADDR_W-1:0] A_PROD_SIZE = 8'h08;
  localparam logic [ADDR_W-1:0] A_PKT_RATE  = 8'h0c;
  localparam logic [ADDR_W-1:0] A_STATE     = 8'h10;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK  = 8'h18;
  // control fields and timeout actions
  localparam int CTRL_CREATE = 0;
  localparam int CTRL_ACT_LO = 1;
  localparam logic [1:0] ACT_TIMED_OUT   = 2'h0;
  localparam logic [1:0] ACT_AUTO_DELETE = 2'h1;
  localparam logic [1:0] ACT_AUTO_RESET  = 2'h2;
  // state register fields
  localparam int ST_EX_BIT   = 4;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_TYPE_LO  = 8;
  localparam int ST_SIZE_LO  = 16;
  // event bits of the interrupt status
  localparam int EV_INT_ERR  = 0;
  localparam int EV_EXPIRE   = 1;
  localparam int EV_DROP     = 2;
  localparam int EV_ERR_RESP = 3;
  // general response codes
  localparam logic [7:0] GEC_OK          = 8'h00;
  localparam logic [7:0] GEC_RES_UNAVAIL = 8'h02;
  localparam logic [7:0] GEC_INV_ATTR    = 8'h09;
  localparam logic [7:0] GEC_BAD_STATE   = 8'h0c;
  localparam logic [7:0] GEC_NO_OBJECT   = 8'h16;
  // instance types (values arbitrary)
  localparam logic [7:0] INST_EXPLICIT = 8'h00;
  localparam logic [7:0] INST_IO       = 8'h01;
  // reset values and sizes
  localparam logic [LEN_W-1:0] RST_CONS_SIZE = 8'h08;
  localparam logic [LEN_W-1:0] RST_PROD_SIZE = 8'h08;
  localparam logic [EPR_W-1:0] RST_PKT_RATE  = 16'h0000;
  localparam logic [LEN_W-1:0] FRAG_BYTES    = 8'h08;
  // watchdog tick: 1 ms at an 8 ns clock
  localparam int TICK_NS  = 1000000;
  localparam int CLK_NS   = 8;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    IO_NONE, IO_CFG, IO_WAIT_ID, IO_EST, IO_TIMED_OUT
  } cos_io_state_type;
  typedef enum logic {EX_NONE, EX_EST} cos_ex_state_type;
endpackage

//--- logic/cos_tmr_if.sv
// carrier between the connection logic and its inactivity timer
`timescale 1ns/1ps
interface cos_tmr_if #(parameter int W = 16);
  logic         restart;
  logic         stop;
  logic [W-1:0] period;
  logic         expire;
  modport ctl (output restart, stop, period, input expire);
  modport tmr (input restart, stop, period, output expire);
endinterface

//--- logic/cos_wdt.sv
// inactivity watchdog timer counting in ticks of a prescaler
`timescale 1ns/1ps
module cos_wdt #(
  parameter int TICK_CYCLES = 125000,
  parameter int W           = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // control
  cos_tmr_if.tmr   tmr
);
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  logic [PRE_W-1:0] pre;
  logic [W-1:0]     count;
  logic             running;

  // prescaler restarts with the timer so the first period is never short
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre <= '0;
    end else if (tmr.restart || !running || pre == PRE_W'(TICK_CYCLES - 1)) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  // a zero period leaves the timer stopped
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      running    <= 1'b0;
      count      <= '0;
      tmr.expire <= 1'b0;
    end else begin
      tmr.expire <= 1'b0;
      if (tmr.restart) begin
        running <= (tmr.period != '0);
        count   <= tmr.period;
      end else if (tmr.stop) begin
        running <= 1'b0;
      end else if (running && pre == PRE_W'(TICK_CYCLES - 1)) begin
        count <= count - 1'b1;
        if (count == W'(1)) begin
          running    <= 1'b0;
          tmr.expire <= 1'b1;
        end
      end
    end
  end
endmodule

//--- tb/cos_conn_logic_tb.sv
// self-checking bench for the connection-object state logic
`timescale 1ns/1ps
module cos_conn_logic_tb;
  import cos_pkg::*;
  logic        sys_clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
  logic [7:0]  addr_in = 8'h00, io_send_len_in = 8'h00, apply_attr_id_in = 8'h00;
  logic [7:0]  ex_open_size_in = 8'h00, ex_set_value_in = 8'h00, rcode, radd, dtot;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic [5:0]  rq = 6'h00;
  logic [7:0]  flg = 8'h00;
  wire logic io_send_in = rq[0], apply_in = rq[1], ex_open_in = rq[2];
  wire logic ex_close_in = rq[3], ex_delete_in = rq[4], ex_set_in = rq[5];
  wire logic apply_need_id_in = flg[0], apply_id_free_in = flg[1];
  wire logic apply_ids_ready_in = flg[2], apply_conflict_in = flg[3];
  wire logic ex_open_is_req_in = flg[4], ex_res_ok_in = flg[5], ex_set_allowed_in = flg[6];
  wire logic io_rx_valid_in, io_rx_more_in;
  wire logic [7:0] io_rx_len_in;
  logic irq_out, io_tx_valid_out, io_tx_frag_out, io_tx_last_out, io_int_err_out;
  logic io_rx_deliver_out, ex_open_resp_out, resp_valid_out;
  logic [7:0] io_tx_bytes_out, io_rx_total_out, resp_code_out, resp_add_out;
  int bad_count = 0, n_checks = 0, cyc = 0, n_resp = 0, exp_resp = 0, n_dlv = 0, n_or = 0;
  int n_fr = 0, n_ie = 0;
  ////////////////////////////////////////
  always #4 sys_clk_in = ~sys_clk_in;
  cos_conn_logic #(.TICK_CYCLES(4)) i_cos_conn_logic (.sys_clk_in, .rst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out, .io_send_in, .io_send_len_in,
    .io_tx_valid_out, .io_tx_bytes_out, .io_tx_frag_out, .io_tx_last_out, .io_int_err_out,
    .io_rx_valid_in, .io_rx_len_in, .io_rx_more_in, .io_rx_deliver_out, .io_rx_total_out,
    .apply_in, .apply_need_id_in, .apply_id_free_in, .apply_ids_ready_in, .apply_conflict_in,
    .apply_attr_id_in, .ex_open_in, .ex_open_is_req_in, .ex_res_ok_in, .ex_open_size_in,
    .ex_close_in, .ex_delete_in, .ex_set_in, .ex_set_allowed_in, .ex_set_value_in,
    .ex_open_resp_out, .resp_valid_out, .resp_code_out, .resp_add_out);
  cos_remote_node i_cos_remote_node (.clk_in(sys_clk_in), .tx_valid_in(io_tx_valid_out),
    .tx_bytes_in(io_tx_bytes_out), .tx_last_in(io_tx_last_out),
    .rx_valid_out(io_rx_valid_in), .rx_len_out(io_rx_len_in), .rx_more_out(io_rx_more_in));
  // catch one-cycle answers; the cycle ceiling cuts a hang short
  always @(posedge sys_clk_in) begin
    cyc++;
    if (resp_valid_out === 1'b1) begin
      n_resp++;
      rcode = resp_code_out;
      radd = resp_add_out;
    end
    if (io_rx_deliver_out === 1'b1) begin
      n_dlv++;
      dtot = io_rx_total_out;
    end
    if (ex_open_resp_out === 1'b1) n_or++;
    if (io_tx_valid_out === 1'b1 && io_tx_frag_out === 1'b1) n_fr++;
    if (io_int_err_out === 1'b1) n_ie++;
    if (cyc == 20000) begin
      bad_count++;
      $display("unexpected at %0t: run hung", $time);
      conclude();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out & m, e);
  endtask
  task ev(input logic [5:0] m, input logic [7:0] f, input logic [7:0] d);
    @(posedge sys_clk_in);
    rq <= m;
    flg <= f;
    {io_send_len_in, apply_attr_id_in, ex_open_size_in, ex_set_value_in} <= {4{d}};
    @(posedge sys_clk_in);
    rq <= 6'h00;
    repeat (3) @(posedge sys_clk_in);
  endtask
  // the answer count catches a missing or extra answer with a repeated code
  task rsp(input logic [7:0] c, input logic [7:0] a);
    exp_resp++;
    chk({n_resp[15:0], radd, rcode}, {exp_resp[15:0], a, c});
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(A_CONS_SIZE, 32'hff, 32'h08);
    rd(8'hfc, 32'hffffffff, 32'h0);
    wr(A_CTRL, 32'h1);
    rd(A_STATE, 32'h7, 32'h1);
    ev(6'h01, 8'h20, 8'h04);
    rd(A_IRQ_STAT, 32'h1, 32'h1);
    chk(n_ie, 1);
    ev(6'h02, 8'h21, 8'h00);
    rsp(8'h02, 8'h00);
    ev(6'h02, 8'h28, 8'h0a);
    rsp(8'h09, 8'h0a);
    ev(6'h02, 8'h20, 8'h00);
    rsp(8'h00, 8'h00);
    rd(A_STATE, 32'h7, 32'h2);
    ev(6'h01, 8'h20, 8'h04);
    ev(6'h02, 8'h24, 8'h00);
    rsp(8'h00, 8'h00);
    rd(A_STATE, 32'h7, 32'h3);
    wr(A_PROD_SIZE, 32'hff);
    wr(A_CONS_SIZE, 32'h0a);
    ev(6'h01, 8'h24, 8'h14);
    repeat (5) @(posedge sys_clk_in);
    chk(i_cos_remote_node.nsum * 256 + i_cos_remote_node.nfrag * 16 + i_cos_remote_node.nlast,
      32'h1431);
    chk(n_fr, 3);
    i_cos_remote_node.rx(8'h04, 1'b1);
    i_cos_remote_node.rx(8'h03, 1'b0);
    chk({n_dlv[7:0], dtot}, 16'h0107);
    i_cos_remote_node.rx(8'h0b, 1'b0);
    i_cos_remote_node.rx(8'h06, 1'b1);
    i_cos_remote_node.rx(8'h06, 1'b0);
    rd(A_IRQ_STAT, 32'h4, 32'h4);
    i_cos_remote_node.rx(8'h0a, 1'b0);
    chk({n_dlv[7:0], dtot}, 16'h020a);
    wr(A_PKT_RATE, 32'h3);
    wr(A_CTRL, 32'h4);
    i_cos_remote_node.rx(8'h03, 1'b0);
    repeat (60) @(posedge sys_clk_in);
    rd(A_STATE, 32'h7, 32'h3);
    wr(A_IRQ_MASK, 32'h2);
    repeat (3) @(posedge sys_clk_in);
    chk(irq_out, 1'b1);
    wr(A_IRQ_MASK, 32'h0);
    // restart first so the next expiry falls after the status clear
    i_cos_remote_node.rx(8'h03, 1'b0);
    wr(A_CTRL, 32'h0);
    wr(A_IRQ_STAT, 32'hf);
    repeat (10) i_cos_remote_node.rx(8'h01, 1'b1);
    rd(A_STATE, 32'h7, 32'h4);
    ev(6'h01, 8'h20, 8'h04);
    rd(A_IRQ_STAT, 32'h3, 32'h3);
    chk(n_ie, 3);
    ev(6'h08, 8'h20, 8'h00);
    rsp(8'h16, 8'h00);
    ev(6'h10, 8'h20, 8'h00);
    rsp(8'h16, 8'h00);
    ev(6'h20, 8'h20, 8'h00);
    rsp(8'h16, 8'h00);
    ev(6'h04, 8'h30, 8'h05);
    rd(A_STATE, 32'hffff10, 32'h050010);
    chk(n_or, 1);
    ev(6'h20, 8'h20, 8'h09);
    rsp(8'h0c, 8'h00);
    ev(6'h20, 8'h60, 8'h09);
    rsp(8'h00, 8'h00);
    rd(A_STATE, 32'hff0000, 32'h090000);
    ev(6'h08, 8'h20, 8'h00);
    rsp(8'h00, 8'h00);
    ev(6'h04, 8'h10, 8'h05);
    rd(A_STATE, 32'h10, 32'h0);
    ev(6'h04, 8'h20, 8'h05);
    chk(n_or, 1);
    ev(6'h10, 8'h20, 8'h00);
    rsp(8'h00, 8'h00);
    rd(A_STATE, 32'h10, 32'h0);
    conclude();
  end
endmodule

//--- tb/cos_remote_node.sv
// remote node model: sends i/o frames to the node, tallies its fragments
`timescale 1ns/1ps
module cos_remote_node (
  // clock
  input  wire logic       clk_in,
  // fragments sent by the node
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_bytes_in,
  input  wire logic       tx_last_in,
  // frames toward the node
  output logic            rx_valid_out = 1'b0,
  output logic [7:0]      rx_len_out = 8'h00,
  output logic            rx_more_out = 1'b0
);
  int nsum = 0, nfrag = 0, nlast = 0;
  ////////////////////////////////////////
  // tally fragments so whole messages can be compared
  always @(posedge clk_in) begin
    if (tx_valid_in === 1'b1) begin
      nsum += tx_bytes_in;
      nfrag++;
      nlast += tx_last_in;
    end
  end
  // one frame a call; lines carry no pull, so they flip once released
  task automatic rx(input logic [7:0] len, input logic more);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_len_out <= len;
    rx_more_out <= more;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_len_out <= ~len;
    rx_more_out <= ~more;
    repeat (3) @(posedge clk_in);
  endtask
endmodule
